//--- sfrie_bank.sv
`timescale 1ns/1ps
`default_nettype none
module sfrie_bank (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire sfrie_pkg::sfrie_req_t i_req,
   input wire logic i_wdt_interval_mode,
   input wire sfrie_pkg::sfrie_irq_t i_irq_flag,
   output logic [7:0] o_rdata,
   output sfrie_pkg::sfrie_irq_t o_irq_req
);
   import sfrie_pkg::*;

   logic watchdog_irq_en_ff;
   logic osc_fault_irq_en_ff;
   logic nonmaskable_irq_en_ff;
   logic flash_violation_irq_en_ff;
   logic serial_rx_irq_en_ff;
   logic serial_tx_irq_en_ff;
   logic interval_timer_irq_en_ff;
   logic wr_first;
   logic wr_second;
   logic [7:0] nxt_rdata;
   sfrie_irq_t nxt_irq_req;

   // Address decode; only two bytes exist
   assign wr_first = i_req.sel & i_req.wr & (i_req.addr == SFRIE_ADDR_FIRST);
   assign wr_second = i_req.sel & i_req.wr & (i_req.addr == SFRIE_ADDR_SECOND);

   // First byte: only six flops, bits 2 and 3 absent
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         watchdog_irq_en_ff <= SFRIE_RST_FIRST[SFRIE_BIT_WDT];
         osc_fault_irq_en_ff <= SFRIE_RST_FIRST[SFRIE_BIT_OSC];
         nonmaskable_irq_en_ff <= SFRIE_RST_FIRST[SFRIE_BIT_NMI];
         flash_violation_irq_en_ff <= SFRIE_RST_FIRST[SFRIE_BIT_FLASH];
         serial_rx_irq_en_ff <= SFRIE_RST_FIRST[SFRIE_BIT_RX];
         serial_tx_irq_en_ff <= SFRIE_RST_FIRST[SFRIE_BIT_TX];
      end else if (wr_first) begin
         watchdog_irq_en_ff <= i_req.wdata[SFRIE_BIT_WDT];
         osc_fault_irq_en_ff <= i_req.wdata[SFRIE_BIT_OSC];
         nonmaskable_irq_en_ff <= i_req.wdata[SFRIE_BIT_NMI];
         flash_violation_irq_en_ff <= i_req.wdata[SFRIE_BIT_FLASH];
         serial_rx_irq_en_ff <= i_req.wdata[SFRIE_BIT_RX];
         serial_tx_irq_en_ff <= i_req.wdata[SFRIE_BIT_TX];
      end
   end

   // Second byte: a single flop in bit 7
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         interval_timer_irq_en_ff <= SFRIE_RST_SECOND[SFRIE_BIT_BT];
      end else if (wr_second) begin
         interval_timer_irq_en_ff <= i_req.wdata[SFRIE_BIT_BT];
      end
   end

   // Read mux; missing bits and other addresses read zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (i_req.sel && !i_req.wr) begin
         if (i_req.addr == SFRIE_ADDR_FIRST) begin
            nxt_rdata[SFRIE_BIT_WDT] = watchdog_irq_en_ff;
            nxt_rdata[SFRIE_BIT_OSC] = osc_fault_irq_en_ff;
            nxt_rdata[SFRIE_BIT_NMI] = nonmaskable_irq_en_ff;
            nxt_rdata[SFRIE_BIT_FLASH] = flash_violation_irq_en_ff;
            nxt_rdata[SFRIE_BIT_RX] = serial_rx_irq_en_ff;
            nxt_rdata[SFRIE_BIT_TX] = serial_tx_irq_en_ff;
         end else if (i_req.addr == SFRIE_ADDR_SECOND) begin
            nxt_rdata[SFRIE_BIT_BT] = interval_timer_irq_en_ff;
         end
      end
   end

   // Enable gating; watchdog enable stays a stored bit but is ignored in reset mode
   always_comb begin
      nxt_irq_req.wdt = i_irq_flag.wdt & watchdog_irq_en_ff & i_wdt_interval_mode;
      nxt_irq_req.osc = i_irq_flag.osc & osc_fault_irq_en_ff;
      nxt_irq_req.nmi = i_irq_flag.nmi & nonmaskable_irq_en_ff;
      nxt_irq_req.flash = i_irq_flag.flash & flash_violation_irq_en_ff;
      nxt_irq_req.rx = i_irq_flag.rx & serial_rx_irq_en_ff;
      nxt_irq_req.tx = i_irq_flag.tx & serial_tx_irq_en_ff;
      nxt_irq_req.bt = i_irq_flag.bt & interval_timer_irq_en_ff;
   end

   // Registered outputs, one cycle of latency
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= 8'h00;
         o_irq_req <= '0;
      end else begin
         o_rdata <= nxt_rdata;
         o_irq_req <= nxt_irq_req;
      end
   end
endmodule
`default_nettype wire

//--- sfrie_pkg.sv
package sfrie_pkg;
   // Byte addresses inside the SFR space
   localparam logic [7:0] SFRIE_ADDR_FIRST = 8'h00;
   localparam logic [7:0] SFRIE_ADDR_SECOND = 8'h01;
   // Bit positions, first byte
   localparam int SFRIE_BIT_WDT = 0;
   localparam int SFRIE_BIT_OSC = 1;
   localparam int SFRIE_BIT_NMI = 4;
   localparam int SFRIE_BIT_FLASH = 5;
   localparam int SFRIE_BIT_RX = 6;
   localparam int SFRIE_BIT_TX = 7;
   // Bit position, second byte
   localparam int SFRIE_BIT_BT = 7;
   localparam logic [7:0] SFRIE_RST_FIRST = 8'h00;
   localparam logic [7:0] SFRIE_RST_SECOND = 8'h00;

   // Peripheral bus request bundle
   typedef struct packed {
      logic       sel;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfrie_req_t;

   // Raw interrupt flags in and gated interrupt requests towards the core
   typedef struct packed {
      logic wdt;
      logic osc;
      logic nmi;
      logic flash;
      logic rx;
      logic tx;
      logic bt;
   } sfrie_irq_t;
endpackage

//--- sfrie_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sfrie_chk (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire sfrie_pkg::sfrie_req_t i_req,
   input wire logic i_wdt_interval_mode,
   input wire sfrie_pkg::sfrie_irq_t i_irq_flag,
   input wire logic [7:0] o_rdata,
   input wire sfrie_pkg::sfrie_irq_t o_irq_req
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   idle_zero_a: assert property (!i_req.sel || i_req.wr |=> o_rdata == 8'h00) else $error("stray rdata");
   hole_zero_a: assert property (i_req.sel |=> (o_rdata & 8'h0C) == 8'h00) else $error("hole bit set");
   wdt_gate_a: assert property (o_irq_req.wdt |-> $past(i_wdt_interval_mode)) else $error("wdt ungated");
   // Second byte holds one flop only, so its low seven bits always read zero
   second_low_a: assert property (i_req.sel && !i_req.wr && i_req.addr == 8'h01 |=> o_rdata[6:0] == 7'h00)
      else $error("second byte low bit set");
   // Addresses past the two bytes decode to nothing
   other_addr_a: assert property (i_req.sel && !i_req.wr && i_req.addr > 8'h01 |=> o_rdata == 8'h00)
      else $error("unmapped read nonzero");
   // Write then read back of the first byte returns the stored bits
   first_back_a: assert property (i_req.sel && i_req.wr && i_req.addr == 8'h00
      ##1 i_req.sel && !i_req.wr && i_req.addr == 8'h00 |=> o_rdata == ($past(i_req.wdata, 2) & 8'hf3))
      else $error("first byte readback wrong");
   // A gated request never appears without its raw flag
   osc_gate_a: assert property (o_irq_req.osc |-> $past(i_irq_flag.osc)) else $error("osc request without flag");
endmodule
bind sfrie_bank sfrie_chk i_chk (.*);
`default_nettype wire

//--- sfrie_core.sv
`timescale 1ns/1ps
`default_nettype none
module sfrie_core (
   input wire logic i_mclk,
   output var sfrie_pkg::sfrie_req_t o_req = '0
);
   // Idle lines invert, so a stale address or data byte cannot pass for a live one
   task acc(input logic s, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      #1 o_req = s ? {1'b1, w, a, d} : {1'b0, ~o_req.wr, ~o_req.addr, ~o_req.wdata};
   endtask
endmodule
`default_nettype wire

//--- sfrie_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sfrie_bank_bench;
   logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_wdt_interval_mode = 1'b1;
   logic [7:0] o_rdata;
   sfrie_pkg::sfrie_req_t i_req;
   sfrie_pkg::sfrie_irq_t i_irq_flag = '1, o_irq_req;
   int n_fail = 0, check_count = 0;
   sfrie_core i_core (.i_mclk(i_mclk), .o_req(i_req));
   sfrie_bank i_dut (.*);
   initial forever #2.5 i_mclk = ~i_mclk;
   task chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      n_fail += (g !== e);
      if (g !== e) $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
   endtask
   // Answer stands one cycle, so sample just after release
   task rd(input logic [7:0] a, input logic [7:0] e);
      i_core.acc(1'b1, 1'b0, a, 8'h00);
      i_core.acc(1'b0, 1'b0, a, 8'h00);
      chk(o_rdata, e);
   endtask
   task test_done();
      $display("test bank done: %0d checks, %0d mismatches", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #13.5 i_sys_rst = 1'b0;
      rd(8'h00, 8'h00);
      i_core.acc(1'b1, 1'b1, 8'h00, 8'hFF);
      rd(8'h00, 8'hF3);
      i_core.acc(1'b1, 1'b1, 8'h01, 8'hFF);
      rd(8'h01, 8'h80);
      $display("test readback done");
      chk({1'b0, o_irq_req}, 8'h7F);
      i_wdt_interval_mode = 1'b0;
      #5 chk({1'b0, o_irq_req}, 8'h3F);
      $display("test gating done");
      i_core.acc(1'b1, 1'b1, 8'h02, 8'hFF);
      rd(8'h02, 8'h00);
      i_core.acc(1'b1, 1'b1, 8'h00, 8'h00);
      rd(8'h00, 8'h00);
      i_core.acc(1'b1, 1'b1, 8'h01, 8'h7F);
      rd(8'h01, 8'h00);
      $display("test clear done");
      test_done();
   end
endmodule
`default_nettype wire
